/* File: pkg/sld_defines.vh */
`ifndef SLD_DEFINES_VH
`define SLD_DEFINES_VH

// ********************************************************
// frame layout
// ********************************************************
`define SLD_SEG_COUNT      32
`define SLD_SEG_MAX        33
`define SLD_CNT_W          6
`define SLD_CNT_IDLE       6'h00
`define SLD_CNT_START      6'h01
`define SLD_CNT_DATA_LAST  6'h22
`define SLD_CNT_LOAD       6'h24

// ********************************************************
// state codes, one-hot
// ********************************************************
`define SLD_ST_W           3
`define SLD_ST_IDLE        3'h1
`define SLD_ST_COUNT       3'h2
`define SLD_ST_CLEAR       3'h4

// ********************************************************
// timing
// ********************************************************
`define SLD_CLOCK_HZ       20000000
`define SLD_BP_FREQ_HZ     75
`define SLD_BP_HALF_CYCLES (`SLD_CLOCK_HZ / (2 * `SLD_BP_FREQ_HZ))
`define SLD_BP_DIV_W       18

// ********************************************************
// reset values
// ********************************************************
`define SLD_LATCH_RST      33'h000000000
`define SLD_SHIFT_RST      33'h000000000

`endif

/* File: src/sld_sync.v */
`timescale 1ns/1ps

// ********************************************************
// two-stage synchroniser for pin inputs
// ********************************************************
module sld_sync #(
  parameter W = 1
) (
  input  wire         clk,
  input  wire         rst_n,
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);

  reg [W-1:0] meta_q;

  // first stage feeds only the second stage
  always @(posedge clk) begin
    if (!rst_n) begin
      meta_q <= {W{1'b0}};
      q      <= {W{1'b0}};
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule // sld_sync

/* File: src/sld_top.v */
`timescale 1ns/1ps
`include "sld_defines.vh"


module sld_top #(
  parameter HAS_DATA_ENABLE = 1,
  parameter BP_HALF_CYCLES  = `SLD_BP_HALF_CYCLES
) (
  input  wire                    CLOCK,
  input  wire                    RSTN,
  input  wire                    SHIFT_CLK,
  input  wire                    SER_DATA,
  input  wire                    DATA_ENABLE,
  input  wire                    BACKPLANE_CLOCK_IN,
  input  wire                    RC_OSCILLATOR_INPUT,
  output reg  [`SLD_SEG_MAX-1:0] SEG_OUT,
  output reg                     BP_OUT
);

  // ********************************************************
  // pin synchronisers
  // ********************************************************
  wire [4:0] pins_s;

  sld_sync #(
    .W (5)
  ) u_sync (
    .clk   (CLOCK),
    .rst_n (RSTN),
    .d     ({RC_OSCILLATOR_INPUT, BACKPLANE_CLOCK_IN, DATA_ENABLE, SER_DATA, SHIFT_CLK}),
    .q     (pins_s)
  );

  wire sclk_s   = pins_s[0];
  wire data_s   = pins_s[1];
  wire den_s    = pins_s[2];
  wire bp_ext_s = pins_s[3];
  wire osc_s    = pins_s[4];

  // ********************************************************
  // shift clock edge detection
  // ********************************************************
  reg sclk_prev_q;

  always @(posedge CLOCK) begin
    if (!RSTN) begin
      sclk_prev_q <= 1'b0;
    end else begin
      sclk_prev_q <= sclk_s;
    end
  end

  // clock and data, plus the enable pin when fitted, are watched; no load strobe exists
  wire sclk_rise = sclk_s & ~sclk_prev_q;
  wire sclk_fall = ~sclk_s & sclk_prev_q;

  // without the enable pin every clock counts
  wire enabled   = (HAS_DATA_ENABLE == 0) | den_s;
  wire adv       = sclk_rise & enabled;

  // ********************************************************
  // frame sequencer
  // ********************************************************
  localparam [`SLD_ST_W-1:0] ST_IDLE  = `SLD_ST_IDLE;
  localparam [`SLD_ST_W-1:0] ST_COUNT = `SLD_ST_COUNT;
  localparam [`SLD_ST_W-1:0] ST_CLEAR = `SLD_ST_CLEAR;

  // ********************************************************
  // frame position decoding
  // ********************************************************
  // clocks 2..34 carry bits; the enable variant drops the 34th later
  function is_data_clock;
    input [`SLD_CNT_W-1:0] c;
    begin
      is_data_clock = (c < `SLD_CNT_DATA_LAST);
    end
  endfunction

  // count before the increment, so one less than the load clock
  function is_load_clock;
    input [`SLD_CNT_W-1:0] c;
    begin
      is_load_clock = (c == (`SLD_CNT_LOAD - 6'h01));
    end
  endfunction

  reg [`SLD_ST_W-1:0]  state_q;
  reg [`SLD_ST_W-1:0]  state_d;
  reg [`SLD_CNT_W-1:0] cnt_q;
  reg [`SLD_CNT_W-1:0] cnt_d;
  reg [`SLD_SEG_MAX-1:0] shift_q;
  reg [`SLD_SEG_MAX-1:0] shift_d;
  reg [`SLD_SEG_MAX-1:0] latch_q;
  reg [`SLD_SEG_MAX-1:0] latch_d;

  always @* begin
    state_d = state_q;
    cnt_d   = cnt_q;
    shift_d = shift_q;
    latch_d = latch_q;
    case (state_q)
      ST_IDLE: begin
        // a one while idle is the start bit
        if (adv && data_s) begin
          state_d = ST_COUNT;
          cnt_d   = `SLD_CNT_START;
        end
      end
      ST_COUNT: begin
        if (adv) begin
          cnt_d = cnt_q + 6'h01;
          // bit 1 ends in the lowest stage after all shifts
          if (is_data_clock(cnt_q)) begin
            shift_d = {data_s, shift_q[`SLD_SEG_MAX-1:1]};
          end
          if (is_load_clock(cnt_q)) begin
            // load on the high phase of the 36th clock
            latch_d = shift_q;
            if (HAS_DATA_ENABLE != 0) begin
              latch_d[`SLD_SEG_MAX-1] = 1'b0;
            end
            state_d = ST_CLEAR;
          end
        end
        // short frames simply wait; no load, no clear
      end
      ST_CLEAR: begin
        // clear on the low phase; counter re-arms so a start bit
        // on the very next rise is still taken
        if (sclk_fall) begin
          shift_d = `SLD_SHIFT_RST;
          cnt_d   = `SLD_CNT_IDLE;
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
        cnt_d   = `SLD_CNT_IDLE;
      end
    endcase
  end

  always @(posedge CLOCK) begin
    if (!RSTN) begin
      state_q <= ST_IDLE;
      cnt_q   <= `SLD_CNT_IDLE;
      shift_q <= `SLD_SHIFT_RST;
      latch_q <= `SLD_LATCH_RST;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      shift_q <= shift_d;
      // latches move only on a completed frame
      latch_q <= latch_d;
    end
  end

  // ********************************************************
  // backplane source
  // ********************************************************
  // rc input high runs the internal divider; tied low selects
  // the external clock, whose duty must be kept by the source
  reg [`SLD_BP_DIV_W-1:0] div_q;
  reg                     bp_int_q;

  always @(posedge CLOCK) begin
    if (!RSTN) begin
      div_q    <= {`SLD_BP_DIV_W{1'b0}};
      bp_int_q <= 1'b0;
    end else if (!osc_s) begin
      div_q    <= {`SLD_BP_DIV_W{1'b0}};
    end else if (div_q == BP_HALF_CYCLES[`SLD_BP_DIV_W-1:0] - 18'h00001) begin
      div_q    <= {`SLD_BP_DIV_W{1'b0}};
      bp_int_q <= ~bp_int_q;
    end else begin
      div_q    <= div_q + 18'h00001;
    end
  end

  wire bp_src = osc_s ? bp_int_q : bp_ext_s;

  // ********************************************************
  // static segment drive
  // ********************************************************
  always @(posedge CLOCK) begin
    if (!RSTN) begin
      BP_OUT <= 1'b0;
    end else begin
      BP_OUT <= bp_src;
    end
  end

  genvar i;
  generate
    for (i = 0; i < `SLD_SEG_MAX; i = i + 1) begin : g_seg
      // one latch bit per pin, no multiplexing
      always @(posedge CLOCK) begin
        if (!RSTN) begin
          SEG_OUT[i] <= 1'b0;
        end else begin
          SEG_OUT[i] <= bp_src ^ latch_q[i];
        end
      end
    end
  endgenerate

endmodule // sld_top

/* File: dv/sld_src_model.sv */
`timescale 1ns/1ps
module sld_src_model (
  input  wire  clk,
  output logic sck,
  output logic sd,
  output logic en
);
  initial begin
    sck = 1'b0;
    sd  = 1'b0;
    en  = 1'b0;
  end
  // link clock stands still between frames
  task automatic send(input logic [35:0] b, input int n, input logic e);
    for (int i = 0; i < n; i++) begin
      sd <= b[i];
      en <= e;
      repeat (4) @(negedge clk);
      sck <= 1'b1;
      repeat (4) @(negedge clk);
      sck <= 1'b0;
    end
  endtask
  // released line shows the inverse of its last bit
  task automatic idle();
    @(negedge clk);
    sd <= ~sd;
    en <= 1'b0;
  endtask
endmodule // sld_src_model

/* File: dv/sld_top_chk.sv */
`timescale 1ns/1ps
module sld_top_chk #(
  parameter HAS_DATA_ENABLE = 1,
  parameter BP_HALF_CYCLES  = 4
) (
  input wire        CLOCK,
  input wire        RSTN,
  input wire        SHIFT_CLK,
  input wire        SER_DATA,
  input wire        DATA_ENABLE,
  input wire        BACKPLANE_CLOCK_IN,
  input wire        RC_OSCILLATOR_INPUT,
  input wire [32:0] SEG_OUT,
  input wire        BP_OUT
);
  reg  [3:0]  since_q;
  reg  [19:0] bpc_q;
  wire [32:0] lat = SEG_OUT ^ {33{BP_OUT}};
  always @(posedge CLOCK) begin
    if (!RSTN) begin
      since_q <= 4'hf;
      bpc_q   <= 20'h0;
    end else begin
      since_q <= $rose(SHIFT_CLK) ? 4'h0 : since_q + {3'h0, ~&since_q};
      bpc_q   <= $changed(BP_OUT) ? 20'h0 : bpc_q + 20'h1;
    end
  end
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RSTN);
  sequence s_quiet; !SHIFT_CLK[*8]; endsequence
  sequence s_no_en; !DATA_ENABLE[*8]; endsequence
  sequence s_ext; !RC_OSCILLATOR_INPUT[*4] ##0 $past(RSTN, 4); endsequence
  sequence s_int; RC_OSCILLATOR_INPUT[*8] ##1 RC_OSCILLATOR_INPUT[*8]; endsequence
  a_rst_clear: assert property ($rose(RSTN) |-> SEG_OUT == 33'h0 && !BP_OUT) else $error("not clear");
  a_latch_hold: assert property (s_quiet |-> $stable(lat)) else $error("latch moved");
  a_enable_gate: assert property (s_no_en ##0 HAS_DATA_ENABLE != 0 |-> $stable(lat)) else $error("gated");
  a_load_time: assert property ($changed(lat) |-> since_q inside {[4'h2:4'h6]}) else $error("load time");
  a_seg_polar: assert property ($changed(BP_OUT) && &since_q |-> SEG_OUT == ~$past(SEG_OUT)) else $error("pol");
  a_seg_extra: assert property (HAS_DATA_ENABLE != 0 |-> SEG_OUT[32] == BP_OUT) else $error("seg 33");
  a_bp_ext: assert property (s_ext |-> BP_OUT == $past(BACKPLANE_CLOCK_IN, 3)) else $error("bp ext");
  a_bp_half: assert property (
    s_int ##0 $changed(BP_OUT) && bpc_q < BP_HALF_CYCLES |-> bpc_q == BP_HALF_CYCLES - 1) else $error("bp half");
endmodule // sld_top_chk
bind sld_top sld_top_chk #(.HAS_DATA_ENABLE(HAS_DATA_ENABLE), .BP_HALF_CYCLES(BP_HALF_CYCLES)) u_chk (
  .CLOCK(CLOCK), .RSTN(RSTN), .SHIFT_CLK(SHIFT_CLK), .SER_DATA(SER_DATA), .DATA_ENABLE(DATA_ENABLE),
  .BACKPLANE_CLOCK_IN(BACKPLANE_CLOCK_IN), .RC_OSCILLATOR_INPUT(RC_OSCILLATOR_INPUT),
  .SEG_OUT(SEG_OUT), .BP_OUT(BP_OUT));

/* File: dv/test_serial_lcd_segment_driver.sv */
`timescale 1ns/1ps
module test_serial_lcd_segment_driver;
  logic        clk, rst_n, backplane_clock_in, rc_in, bp, bp_p;
  wire         sck, sd, en;
  logic [32:0] seg, seg2, sh2, exp2;
  logic [31:0] sh, exp_l;
  logic [35:0] b;
  logic        bp2;
  int          err_count, n_tests, cnt, cnt2, seed, tog;
  sld_top #(.HAS_DATA_ENABLE(1), .BP_HALF_CYCLES(4)) DUT (.CLOCK(clk), .RSTN(rst_n), .SHIFT_CLK(sck),
    .SER_DATA(sd), .DATA_ENABLE(en), .BACKPLANE_CLOCK_IN(backplane_clock_in), .RC_OSCILLATOR_INPUT(rc_in),
    .SEG_OUT(seg), .BP_OUT(bp));
  // variant without enable: 33 outputs, enable pin ignored
  sld_top #(.HAS_DATA_ENABLE(0), .BP_HALF_CYCLES(4)) DUT_B (.CLOCK(clk), .RSTN(rst_n), .SHIFT_CLK(sck),
    .SER_DATA(sd), .DATA_ENABLE(en), .BACKPLANE_CLOCK_IN(backplane_clock_in), .RC_OSCILLATOR_INPUT(rc_in),
    .SEG_OUT(seg2), .BP_OUT(bp2));
  sld_src_model u_src (.clk(clk), .sck(sck), .sd(sd), .en(en));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic check(input string nm, input logic [32:0] seen, input logic [32:0] want);
    n_tests++;
    if (seen !== want) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, want, seen);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // reference: a one while idle starts a frame; only enabled rises count for DUT, every rise for DUT_B
  task automatic frame(input logic [35:0] fb, input int n, input logic e);
    for (int i = 0; i < n; i++) begin
      if (e && cnt > 0) cnt++;
      else if (e && fb[i]) cnt = 1;
      if (cnt >= 2 && cnt <= 33) sh[cnt-2] = fb[i];
      if (cnt == 36) begin
        exp_l = sh;
        cnt = 0;
      end
      if (cnt2 > 0) cnt2++;
      else if (fb[i]) cnt2 = 1;
      if (cnt2 >= 2 && cnt2 <= 34) sh2[cnt2-2] = fb[i];
      if (cnt2 == 36) begin
        exp2 = sh2;
        cnt2 = 0;
      end
    end
    u_src.send(fb, n, e);
  endtask
  task automatic check_lat();
    u_src.idle();
    repeat (8) @(negedge clk);
    check("latch", seg ^ {33{bp}}, {1'b0, exp_l});
    check("latch 33", seg2 ^ {33{bp2}}, exp2);
  endtask
  initial begin
    seed = 87560;
    {err_count, n_tests, cnt, cnt2, exp_l, sh, exp2, sh2} = '0;
    {rst_n, backplane_clock_in, rc_in} = 3'h0;
    repeat (16) @(negedge clk);
    rst_n <= 1'b1;
    repeat (4) @(negedge clk);
    check("seg reset", {seg[32:1], seg[0] | bp}, 33'h0);
    for (int i = 0; i < 7; i++) begin
      b = {3'($random(seed)), i == 0 ? 32'hffffffff : i == 1 ? 32'h0 : 32'($random(seed)), 1'b1};
      frame(b, 36, 1'b1);
      if (i != 4) check_lat();
    end
    frame({$random(seed), 4'($random(seed))}, 20, 1'b1);
    check_lat();
    frame(36'($random(seed)), 16, 1'b1);
    check_lat();
    frame({$random(seed), 4'h1}, 36, 1'b0);
    check_lat();
    rc_in <= 1'b1;
    tog = 0;
    bp_p = bp;
    repeat (40) begin
      @(negedge clk);
      tog += int'(bp !== bp_p);
      bp_p = bp;
      check("polarity", seg ^ {33{bp}}, {1'b0, exp_l});
    end
    check("bp toggles", 33'(tog >= 9 && tog <= 10), 33'h1);
    rc_in <= 1'b0;
    for (int k = 1; k >= 0; k--) begin
      // equal high and low spans keep the external clock at half duty
      backplane_clock_in <= k[0];
      repeat (6) @(negedge clk);
      check("bp ext", seg, {1'b0, exp_l} ^ {33{k[0]}});
    end
    end_of_test();
  end
  initial begin
    #1000000;
    err_count++;
    end_of_test();
  end
endmodule // test_serial_lcd_segment_driver
